/* verilog/spa_dev.sv */
// device end: serial command decoder and programming test port
module spa_dev (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pins
  spa_if.dev pins,
  // fuse and calibration contents
  input wire logic [7:0] ext_fuse,
  input wire logic [7:0] high_fuse,
  input wire logic [31:0] cal_bytes,
  input wire logic test_port_enable_fuse,
  // control and status bit writes
  input wire logic disable_set,
  // status
  output logic serial_prog_mode,
  output logic tap_prog_mode,
  output logic prog_clk,
  output logic [3:0] tap_ir,
  output logic test_port_disable_bit,
  output logic test_port_on
);

  typedef struct packed {
    logic [2:0] s_sck;
    logic [2:0] s_mosi;
    logic [2:0] s_rst;
    logic [2:0] s_tck;
    logic [2:0] s_tms;
    logic [2:0] s_tdi;
    logic f_sck;
    logic f_rst;
    logic f_tck;
    logic [4:0] bits;
    logic [31:0] cmd;
    logic [7:0] out;
    logic miso;
    logic ser_en;
    spa_pkg::spa_tap_e tap;
    logic [3:0] ir_sr;
    logic [3:0] ir;
    logic [15:0] dr;
    logic byp;
    logic tdo;
    logic jtag_en;
    logic pclk;
    logic dis;
    logic [1:0] dis_cnt;
  } spa_dev_s;

  spa_dev_s st;
  spa_dev_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic spa_pkg::spa_tap_e spa_tap_next(spa_pkg::spa_tap_e s, logic tms);
    case (s)
      spa_pkg::TAP_TLR: spa_tap_next = tms ? spa_pkg::TAP_TLR : spa_pkg::TAP_RTI;
      spa_pkg::TAP_RTI: spa_tap_next = tms ? spa_pkg::TAP_SEL_DR : spa_pkg::TAP_RTI;
      spa_pkg::TAP_SEL_DR: spa_tap_next = tms ? spa_pkg::TAP_SEL_IR : spa_pkg::TAP_CAP_DR;
      spa_pkg::TAP_CAP_DR: spa_tap_next = tms ? spa_pkg::TAP_EX1_DR : spa_pkg::TAP_SH_DR;
      spa_pkg::TAP_SH_DR: spa_tap_next = tms ? spa_pkg::TAP_EX1_DR : spa_pkg::TAP_SH_DR;
      spa_pkg::TAP_EX1_DR: spa_tap_next = tms ? spa_pkg::TAP_UP_DR : spa_pkg::TAP_PA_DR;
      spa_pkg::TAP_PA_DR: spa_tap_next = tms ? spa_pkg::TAP_EX2_DR : spa_pkg::TAP_PA_DR;
      spa_pkg::TAP_EX2_DR: spa_tap_next = tms ? spa_pkg::TAP_UP_DR : spa_pkg::TAP_SH_DR;
      spa_pkg::TAP_UP_DR: spa_tap_next = tms ? spa_pkg::TAP_SEL_DR : spa_pkg::TAP_RTI;
      spa_pkg::TAP_SEL_IR: spa_tap_next = tms ? spa_pkg::TAP_TLR : spa_pkg::TAP_CAP_IR;
      spa_pkg::TAP_CAP_IR: spa_tap_next = tms ? spa_pkg::TAP_EX1_IR : spa_pkg::TAP_SH_IR;
      spa_pkg::TAP_SH_IR: spa_tap_next = tms ? spa_pkg::TAP_EX1_IR : spa_pkg::TAP_SH_IR;
      spa_pkg::TAP_EX1_IR: spa_tap_next = tms ? spa_pkg::TAP_UP_IR : spa_pkg::TAP_PA_IR;
      spa_pkg::TAP_PA_IR: spa_tap_next = tms ? spa_pkg::TAP_EX2_IR : spa_pkg::TAP_PA_IR;
      spa_pkg::TAP_EX2_IR: spa_tap_next = tms ? spa_pkg::TAP_UP_IR : spa_pkg::TAP_SH_IR;
      spa_pkg::TAP_UP_IR: spa_tap_next = tms ? spa_pkg::TAP_SEL_DR : spa_pkg::TAP_RTI;
      default: spa_tap_next = spa_pkg::TAP_TLR;
    endcase
  endfunction : spa_tap_next

  // answer for the first three bytes of a read command
  function automatic logic [7:0] spa_read_byte(logic [23:0] c, logic [7:0] ef,
                                              logic [7:0] hf, logic [31:0] cal);
    logic [1:0] sel;
    sel = c[spa_pkg::CAL_SEL_HI:spa_pkg::CAL_SEL_LO];
    spa_read_byte = 8'h00;
    if (c[23:16] == spa_pkg::CMD_RD_EXT_B1 && c[15:8] == spa_pkg::CMD_RD_FUSE_B2) begin
      spa_read_byte = ef;
    end else if (c[23:16] == spa_pkg::CMD_RD_HIGH_B1 && c[15:8] == spa_pkg::CMD_RD_FUSE_B2) begin
      spa_read_byte = hf;
    end else if (c[23:16] == spa_pkg::CMD_RD_CAL_B1) begin
      spa_read_byte = cal[sel*8 +: 8];
    end
  endfunction : spa_read_byte

  // edge on a synchronised pin, counted once second and third stage agree
  function automatic logic [1:0] spa_edges(logic [2:0] s, logic f);
    spa_edges = {s[1] == s[2] && s[2] && !f, s[1] == s[2] && !s[2] && f};
  endfunction : spa_edges

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [1:0] sck_e;
  logic [1:0] tck_e;
  logic tap_en;
  logic [7:0] rd;

  always_comb begin
    next_st = st;
    next_st.pclk = 1'b0;
    sck_e = spa_edges(st.s_sck, st.f_sck);
    tck_e = spa_edges(st.s_tck, st.f_tck);
    tap_en = test_port_enable_fuse && !st.dis;
    rd = spa_read_byte({st.cmd[22:0], st.s_mosi[2]}, ext_fuse, high_fuse, cal_bytes);
    next_st.s_sck = {st.s_sck[1:0], pins.sck};
    next_st.s_mosi = {st.s_mosi[1:0], pins.mosi};
    next_st.s_rst = {st.s_rst[1:0], pins.rst_n};
    next_st.s_tck = {st.s_tck[1:0], pins.tck};
    next_st.s_tms = {st.s_tms[1:0], pins.tms};
    next_st.s_tdi = {st.s_tdi[1:0], pins.tdi};
    if (st.s_sck[1] == st.s_sck[2]) begin
      next_st.f_sck = st.s_sck[2];
    end
    if (st.s_rst[1] == st.s_rst[2]) begin
      next_st.f_rst = st.s_rst[2];
    end
    if (st.s_tck[1] == st.s_tck[2]) begin
      next_st.f_tck = st.s_tck[2];
    end

    // serial command path, live while reset pin is low
    if (st.f_rst) begin
      next_st.bits = 5'h00;
      next_st.ser_en = 1'b0;
      next_st.miso = 1'b0;
      next_st.out = 8'h00;
    end else if (sck_e[1]) begin
      next_st.cmd = {st.cmd[30:0], st.s_mosi[2]};
      next_st.bits = st.bits + 5'h01;
      if (st.bits == spa_pkg::CMD_EN_LAST && st.cmd[14:7] == spa_pkg::CMD_EN_B1 &&
          {st.cmd[6:0], st.s_mosi[2]} == spa_pkg::CMD_EN_B2) begin
        next_st.ser_en = 1'b1;
      end
      if (st.bits == spa_pkg::CMD_B3_LAST) begin
        next_st.out = st.ser_en ? rd : 8'h00;
        next_st.miso = next_st.out[7];
      end
    end else if (sck_e[0] && st.bits > spa_pkg::CMD_B4_FIRST) begin
      next_st.out = {st.out[6:0], 1'b0};
      next_st.miso = next_st.out[7];
    end

    // disable bit: set by software wins, cleared by held reset
    if (disable_set) begin
      next_st.dis = 1'b1;
      next_st.dis_cnt = 2'h0;
    end else if (!st.f_rst && st.dis) begin
      if (st.dis_cnt == 2'(spa_pkg::DIS_CLR_CYCLES - 1)) begin
        next_st.dis = 1'b0;
        next_st.dis_cnt = 2'h0;
      end else begin
        next_st.dis_cnt = st.dis_cnt + 2'h1;
      end
    end else begin
      next_st.dis_cnt = 2'h0;
    end

    // test port
    if (!tap_en) begin
      next_st.tap = spa_pkg::TAP_TLR;
      next_st.ir = spa_pkg::IR_BYPASS;
      next_st.jtag_en = 1'b0;
      next_st.tdo = 1'b0;
    end else if (tck_e[1]) begin
      case (st.tap)
        spa_pkg::TAP_TLR: begin
          next_st.ir = spa_pkg::IR_BYPASS;
          next_st.jtag_en = 1'b0;
        end
        spa_pkg::TAP_RTI: begin
          next_st.pclk = 1'b1;
        end
        spa_pkg::TAP_CAP_IR: begin
          next_st.ir_sr = spa_pkg::IR_CAPTURE;
        end
        spa_pkg::TAP_SH_IR: begin
          next_st.ir_sr = {st.s_tdi[2], st.ir_sr[3:1]};
        end
        spa_pkg::TAP_UP_IR: begin
          next_st.ir = st.ir_sr;
        end
        spa_pkg::TAP_CAP_DR: begin
          next_st.byp = 1'b0;
        end
        spa_pkg::TAP_SH_DR: begin
          if (st.ir == spa_pkg::IR_PROG_ENTRY) begin
            next_st.dr = {st.s_tdi[2], st.dr[15:1]};
          end else begin
            next_st.byp = st.s_tdi[2];
          end
        end
        spa_pkg::TAP_UP_DR: begin
          if (st.ir == spa_pkg::IR_PROG_ENTRY) begin
            next_st.jtag_en = st.dr == spa_pkg::ENTRY_SIGNATURE;
          end
        end
        default: begin
        end
      endcase
      next_st.tap = spa_tap_next(st.tap, st.s_tms[2]);
    end else if (tck_e[0]) begin
      if (st.tap == spa_pkg::TAP_SH_IR) begin
        next_st.tdo = st.ir_sr[0];
      end else if (st.ir == spa_pkg::IR_PROG_ENTRY) begin
        next_st.tdo = st.dr[0];
      end else begin
        next_st.tdo = st.byp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.s_rst <= 3'h7;
      st.f_rst <= 1'b1;
      st.tap <= spa_pkg::TAP_TLR;
      st.ir <= spa_pkg::IR_BYPASS;
      st.ir_sr <= spa_pkg::IR_CAPTURE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pins.miso = st.miso;
  assign pins.miso_oe = !st.f_rst;
  assign pins.tdo = st.tdo;
  assign pins.tdo_oe = tap_en && (st.tap == spa_pkg::TAP_SH_IR || st.tap == spa_pkg::TAP_SH_DR);
  assign serial_prog_mode = st.ser_en;
  assign tap_prog_mode = st.jtag_en;
  assign prog_clk = st.pclk;
  assign tap_ir = st.ir;
  assign test_port_disable_bit = st.dis;
  assign test_port_on = tap_en;

endmodule : spa_dev

/* verilog/spa_pkg.sv */
// constants, tap states and timing for the serial programming access block
package spa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // serial command bytes
  localparam logic [7:0] CMD_EN_B1 = 8'hac;
  localparam logic [7:0] CMD_EN_B2 = 8'h53;
  localparam logic [7:0] CMD_RD_EXT_B1 = 8'h50;
  localparam logic [7:0] CMD_RD_HIGH_B1 = 8'h58;
  localparam logic [7:0] CMD_RD_FUSE_B2 = 8'h08;
  localparam logic [7:0] CMD_RD_CAL_B1 = 8'h38;
  localparam logic [4:0] CMD_BITS_LAST = 5'h1f;
  localparam logic [4:0] CMD_EN_LAST = 5'h0f;
  localparam logic [4:0] CMD_B3_LAST = 5'h17;
  localparam logic [4:0] CMD_B4_FIRST = 5'h18;
  localparam int CAL_SEL_HI = 7;
  localparam int CAL_SEL_LO = 6;

  ////////////////////////////////////////////////////////////////////////////
  // test port
  localparam int IR_W = 4;
  localparam int EN_DR_W = 16;
  localparam logic [3:0] IR_PROG_ENTRY = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  // arbitrary value
  localparam logic [15:0] ENTRY_SIGNATURE = 16'h5a3c;

  typedef enum logic [3:0] {
    TAP_EX2_DR = 4'h0,
    TAP_EX1_DR = 4'h1,
    TAP_SH_DR = 4'h2,
    TAP_PA_DR = 4'h3,
    TAP_SEL_IR = 4'h4,
    TAP_UP_DR = 4'h5,
    TAP_CAP_DR = 4'h6,
    TAP_SEL_DR = 4'h7,
    TAP_EX2_IR = 4'h8,
    TAP_EX1_IR = 4'h9,
    TAP_SH_IR = 4'ha,
    TAP_PA_IR = 4'hb,
    TAP_RTI = 4'hc,
    TAP_UP_IR = 4'hd,
    TAP_CAP_IR = 4'he,
    TAP_TLR = 4'hf
  } spa_tap_e;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SYS_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 1000;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / SYS_PERIOD_NS / 2;
  localparam int DIS_CLR_CYCLES = 2;
  localparam int SYNC_W = 3;

endpackage : spa_pkg

/* verilog/spa_if.sv */
// pins between the programmer and the device
interface spa_if;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic rst_n;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic miso_w;
  logic tdo_w;

  // undriven outputs float high (pull-up)
  assign miso_w = miso_oe ? miso : 1'b1;
  assign tdo_w = tdo_oe ? tdo : 1'b1;

  modport dev (
    input sck, mosi, rst_n, tck, tms, tdi,
    output miso, miso_oe, tdo, tdo_oe
  );

  modport host (
    output sck, mosi, rst_n, tck, tms, tdi,
    input miso_w, tdo_w
  );
endinterface : spa_if

/* verilog/spa_host.sv */
// programmer end: serial commands and raw test port scans
module spa_host #(
  parameter int HALF_CYC = spa_pkg::LINK_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pins
  spa_if.host pins,
  // request
  input wire logic start,
  input wire logic tap_mode,
  input wire logic [31:0] tx_bits,
  input wire logic [31:0] tms_bits,
  input wire logic [5:0] tap_len,
  input wire logic hold_reset,
  // answer
  output logic busy,
  output logic done,
  output logic [31:0] rx_bits
);

  typedef struct packed {
    logic [2:0] s_miso;
    logic [2:0] s_tdo;
    logic mode;
    logic busy;
    logic done;
    logic lvl;
    logic [7:0] div;
    logic [5:0] left;
    logic [31:0] tx;
    logic [31:0] tms;
    logic [31:0] rx;
    logic sck;
    logic mosi;
    logic tck;
    logic tmso;
    logic tdi;
    logic rst_low;
  } spa_host_s;

  spa_host_s st;
  spa_host_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.s_miso = {st.s_miso[1:0], pins.miso_w};
    next_st.s_tdo = {st.s_tdo[1:0], pins.tdo_w};
    next_st.rst_low = hold_reset;
    if (!st.busy) begin
      if (start) begin
        next_st.busy = 1'b1;
        next_st.mode = tap_mode;
        next_st.tx = tx_bits;
        next_st.tms = tms_bits;
        next_st.left = tap_mode ? tap_len : 6'h20;
        next_st.div = 8'h00;
        next_st.lvl = 1'b0;
        next_st.rx = 32'h0;
        if (tap_mode) begin
          next_st.tdi = tx_bits[0];
          next_st.tmso = tms_bits[0];
        end else begin
          next_st.mosi = tx_bits[31];
        end
      end
    end else if (st.div != 8'(HALF_CYC - 1)) begin
      next_st.div = st.div + 8'h01;
    end else begin
      next_st.div = 8'h00;
      if (!st.lvl) begin
        // sample just before the rising edge
        next_st.lvl = 1'b1;
        if (st.mode) begin
          next_st.rx = {st.s_tdo[2], st.rx[31:1]};
          next_st.tck = 1'b1;
        end else begin
          next_st.rx = {st.rx[30:0], st.s_miso[2]};
          next_st.sck = 1'b1;
        end
      end else begin
        next_st.lvl = 1'b0;
        next_st.sck = 1'b0;
        next_st.tck = 1'b0;
        next_st.left = st.left - 6'h01;
        if (st.left == 6'h01) begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end else if (st.mode) begin
          next_st.tx = {1'b0, st.tx[31:1]};
          next_st.tms = {1'b0, st.tms[31:1]};
          next_st.tdi = st.tx[1];
          next_st.tmso = st.tms[1];
        end else begin
          next_st.tx = {st.tx[30:0], 1'b0};
          next_st.mosi = st.tx[30];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.s_miso <= 3'h7;
      st.s_tdo <= 3'h7;
      st.tmso <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // only clock, select and data pins matter on the test port
  assign pins.sck = st.sck;
  assign pins.mosi = st.mosi;
  assign pins.rst_n = !st.rst_low;
  assign pins.tck = st.tck;
  assign pins.tms = st.tmso;
  assign pins.tdi = st.tdi;
  assign busy = st.busy;
  assign done = st.done;
  assign rx_bits = st.rx;

endmodule : spa_host

/* sim/spa_asserts.sv */
// concurrent checks on the programming pins and device status
module spa_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_oe,
  input wire logic miso_oe,
  // device status
  input wire logic test_port_on,
  input wire logic test_port_disable_bit,
  input wire logic serial_prog_mode,
  input wire logic tap_prog_mode,
  input wire logic prog_clk,
  input wire logic [3:0] tap_ir
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  property p_tdo_off;
    !test_port_on |=> !tdo_oe;
  endproperty
  a_tdo_off: assert property (p_tdo_off) else $error("tdo driven with port off");
  property p_ir_off;
    !test_port_on [*2] |-> tap_ir == spa_pkg::IR_BYPASS;
  endproperty
  a_ir_off: assert property (p_ir_off) else $error("ir not parked");
  property p_dis_clr;
    (!rst_n) [*8] |-> !test_port_disable_bit;
  endproperty
  a_dis_clr: assert property (p_dis_clr) else $error("disable bit kept");
  property p_miso_off;
    rst_n [*8] |-> !miso_oe && !serial_prog_mode;
  endproperty
  a_miso_off: assert property (p_miso_off) else $error("serial active out of reset");
  property p_spm_rise;
    $rose(serial_prog_mode) |-> !rst_n;
  endproperty
  a_spm_rise: assert property (p_spm_rise) else $error("serial entry without reset");
  property p_prog_clk;
    prog_clk |-> test_port_on ##1 !prog_clk;
  endproperty
  a_prog_clk: assert property (p_prog_clk) else $error("bad internal clock pulse");
  property p_tap_entry;
    $rose(tap_prog_mode) |-> tap_ir == spa_pkg::IR_PROG_ENTRY;
  endproperty
  a_tap_entry: assert property (p_tap_entry) else $error("entry without opcode");
  property p_mosi_hold;
    !$stable(mosi) |-> !sck;
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at sck high");
  property p_tap_hold;
    !$stable(tdi) || !$stable(tms) |-> !tck;
  endproperty
  a_tap_hold: assert property (p_tap_hold) else $error("tdi or tms moved at tck high");
endmodule : spa_asserts

/* sim/tb.sv */
// testbench: programmer end and device end joined over the pins
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] ext_fuse = 8'hfd;
  logic [7:0] high_fuse = 8'h1c;
  logic [31:0] cal_bytes = 32'ha1b2c3d4;
  logic test_port_enable_fuse = 1'b1;
  logic disable_set = 1'b0;
  logic start = 1'b0;
  logic tap_mode = 1'b0;
  logic [31:0] tx_bits = 32'h0;
  logic [31:0] tms_bits = 32'h0;
  logic [5:0] tap_len = 6'h01;
  logic hold_reset = 1'b0;
  logic serial_prog_mode, tap_prog_mode, prog_clk, test_port_disable_bit, test_port_on;
  logic [3:0] tap_ir;
  logic busy, done;
  logic [31:0] rx_bits, rx;
  int mismatches = 0;
  int total_checks = 0;
  int pulses = 0;

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (prog_clk === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  ////////////////////////////////////////
  spa_if i_spa_if ();
  spa_dev i_spa_dev (.sys_clk(sys_clk), .nrst(nrst), .pins(i_spa_if.dev),
    .ext_fuse(ext_fuse), .high_fuse(high_fuse), .cal_bytes(cal_bytes),
    .test_port_enable_fuse(test_port_enable_fuse), .disable_set(disable_set),
    .serial_prog_mode(serial_prog_mode), .tap_prog_mode(tap_prog_mode),
    .prog_clk(prog_clk), .tap_ir(tap_ir), .test_port_disable_bit(test_port_disable_bit),
    .test_port_on(test_port_on));
  spa_host i_spa_host (.sys_clk(sys_clk), .nrst(nrst), .pins(i_spa_if.host),
    .start(start), .tap_mode(tap_mode), .tx_bits(tx_bits), .tms_bits(tms_bits),
    .tap_len(tap_len), .hold_reset(hold_reset), .busy(busy), .done(done), .rx_bits(rx_bits));
  spa_asserts i_spa_asserts (.sys_clk(sys_clk), .nrst(nrst), .sck(i_spa_if.sck),
    .mosi(i_spa_if.mosi), .rst_n(i_spa_if.rst_n), .tck(i_spa_if.tck), .tms(i_spa_if.tms),
    .tdi(i_spa_if.tdi), .tdo_oe(i_spa_if.tdo_oe), .miso_oe(i_spa_if.miso_oe),
    .test_port_on(test_port_on), .test_port_disable_bit(test_port_disable_bit),
    .serial_prog_mode(serial_prog_mode), .tap_prog_mode(tap_prog_mode),
    .prog_clk(prog_clk), .tap_ir(tap_ir));
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  // one host transfer, waits for done under a bound
  task automatic scan(input logic mode, input logic [31:0] tx, input logic [31:0] tm,
                      input logic [5:0] len);
    int n;
    n = 0;
    tap_mode = mode;
    tx_bits = tx;
    tms_bits = tm;
    tap_len = len;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    chk("busy", 32'h1, 32'(busy));
    while (done !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk("done", 32'h1, 32'(done));
    chk("busy", 32'h0, 32'(busy));
    rx = rx_bits;
    tick(1);
  endtask : scan

  task automatic test_tap();
    scan(1'b1, 32'h80, 32'h306, 6'h0b);
    chk("tap_ir", 32'h4, 32'(tap_ir));
    chk("ir capture", 32'h63f, 32'(rx[31:21]));
    scan(1'b1, 32'(spa_pkg::ENTRY_SIGNATURE) << 3, 32'hc0001, 6'h15);
    chk("tap_prog_mode", 32'h1, 32'(tap_prog_mode));
    pulses = 0;
    scan(1'b1, 32'h0, 32'h0, 6'h05);
    chk("prog_clk count", 32'h5, 32'(pulses));
    scan(1'b1, 32'(~spa_pkg::ENTRY_SIGNATURE) << 3, 32'hc0001, 6'h15);
    chk("tap_prog_mode", 32'h0, 32'(tap_prog_mode));
    chk("dr out", 32'(spa_pkg::ENTRY_SIGNATURE), 32'(rx[29:14]));
    $display("test tap finished");
  endtask : test_tap

  task automatic test_serial();
    hold_reset = 1'b1;
    tick(10);
    scan(1'b0, 32'h58080000, 32'h0, 6'h20);
    chk("read before entry", 32'h0, 32'(rx[7:0]));
    scan(1'b0, 32'hac530000, 32'h0, 6'h20);
    chk("serial_prog_mode", 32'h1, 32'(serial_prog_mode));
    scan(1'b0, 32'h58080000, 32'h0, 6'h20);
    chk("high fuse", 32'(high_fuse), 32'(rx[7:0]));
    scan(1'b0, 32'h50080000, 32'h0, 6'h20);
    chk("ext fuse", 32'(ext_fuse), 32'(rx[7:0]));
    for (int d = 0; d < 4; d++) begin
      scan(1'b0, 32'h38000000 | (32'(d) << 14), 32'h0, 6'h20);
      chk("cal byte", 32'(cal_bytes[8*d +: 8]), 32'(rx[7:0]));
    end
    hold_reset = 1'b0;
    tick(12);
    chk("serial_prog_mode", 32'h0, 32'(serial_prog_mode));
    $display("test serial finished");
  endtask : test_serial

  task automatic test_disable();
    disable_set = 1'b1;
    tick(1);
    disable_set = 1'b0;
    tick(2);
    chk("disable bit", 32'h1, 32'(test_port_disable_bit));
    chk("test_port_on", 32'h0, 32'(test_port_on));
    scan(1'b1, 32'h80, 32'h306, 6'h0b);
    chk("tap_ir", 32'hf, 32'(tap_ir));
    hold_reset = 1'b1;
    tick(10);
    chk("disable bit", 32'h0, 32'(test_port_disable_bit));
    hold_reset = 1'b0;
    test_port_enable_fuse = 1'b0;
    scan(1'b1, 32'h80, 32'h306, 6'h0b);
    chk("tap_ir", 32'hf, 32'(tap_ir));
    test_port_enable_fuse = 1'b1;
    tick(2);
    chk("test_port_on", 32'h1, 32'(test_port_on));
    scan(1'b1, 32'h50, 32'h182, 6'h0a);
    chk("bypass", 32'h3af, 32'(rx[31:22]));
    $display("test disable finished");
  endtask : test_disable

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    tick(3);
    nrst = 1'b1;
    tick(1);
    test_tap();
    test_serial();
    test_disable();
    final_report();
  end

  // hang guard, about six times the expected run
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
endmodule : tb
